// ### lgs_pkg.sv
// Purpose: Shared constants for the grayscale and scroll display control block
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Opcodes, parameter counts, reset values and timing counts live here
package lgs_pkg;

  // Command opcodes
  localparam logic [7:0] OP_GRAY = 8'hbc;
  localparam logic [7:0] OP_DUTY = 8'hca;
  localparam logic [7:0] OP_AREA = 8'haa;
  localparam logic [7:0] OP_START = 8'hab;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_NORMAL = 8'ha6;
  localparam logic [7:0] OP_INVERSE = 8'ha7;
  localparam logic [7:0] OP_PART_ON = 8'ha8;
  localparam logic [7:0] OP_PART_OFF = 8'ha9;
  localparam logic [7:0] OP_DISP_ON = 8'haf;
  localparam logic [7:0] OP_DISP_OFF = 8'hae;
  localparam logic [7:0] OP_SLEEP_IN = 8'h95;
  localparam logic [7:0] OP_SLEEP_OUT = 8'h94;
  localparam logic [7:0] OP_OSC_ON = 8'hd1;
  localparam logic [7:0] OP_OSC_OFF = 8'hd2;
  localparam logic [7:0] OP_NOP = 8'h25;

  // Parameter bytes each command takes
  localparam logic [2:0] NPAR_GRAY = 3'h2;
  localparam logic [2:0] NPAR_DUTY = 3'h1;
  localparam logic [2:0] NPAR_AREA = 3'h4;
  localparam logic [2:0] NPAR_START = 3'h1;
  localparam logic [2:0] NPAR_CONTRAST = 3'h2;
  localparam logic [2:0] NPAR_PART = 3'h2;

  // Gray shading
  localparam logic [3:0] PWM_PERIOD = 4'hf;
  localparam logic [3:0] PWM_LAST = 4'he;
  localparam logic [3:0] PWM_WHITE = 4'h0;
  localparam logic [3:0] PWM_LIGHT_DEF = 4'h5;
  localparam logic [3:0] PWM_DARK_DEF = 4'ha;
  localparam logic [3:0] PWM_BLACK = 4'hf;
  localparam logic [1:0] FRC3_LAST = 2'h2;
  localparam logic [1:0] FRC4_LAST = 2'h3;

  // Scroll geometry
  localparam int LINES_PER_BLOCK_LOG2 = 2;
  localparam logic [5:0] BLOCK_TOP = 6'h00;
  localparam logic [5:0] BLOCK_BOTTOM = 6'h20;
  localparam logic [7:0] MUX_MAX_LINES = 8'h82;
  localparam logic [5:0] DUTY_CODE_MAX = 6'h20;

  // Reset values
  localparam logic [5:0] DUTY_RST = 6'h1f;
  localparam logic [5:0] CONTRAST_RST = 6'h20;
  localparam logic [2:0] GAIN_RST = 3'h0;
  localparam logic [1:0] SCROLL_TYPE_RST = 2'h0;

  typedef enum logic [1:0] {
    LGS_IDLE = 2'b00,
    LGS_PARAM = 2'b01
  } lgs_dec_type;

endpackage

// ### lgs_shade.sv
// Purpose: Decides whether one pixel is dark in the current PWM count and frame
// Assumes: Counters supplied by the caller, pixel already inverted if needed
// Notes: Purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module lgs_shade
  import lgs_pkg::*;
(
  input wire logic [1:0] pixel_in,
  input wire logic gray_method_select_in,
  input wire logic pwm_custom_select_in,
  input wire logic [2:0] light_gray_count_field_in,
  input wire logic [2:0] dark_gray_delta_field_in,
  input wire logic frc_length_select_in,
  input wire logic [1:0] frc_pattern_select_in,
  input wire logic [3:0] pwm_count_in,
  input wire logic [1:0] frame_in,
  output logic dark_out
);

  logic [3:0] light_cnt;
  logic [4:0] dark_sum;
  logic [3:0] dark_cnt;
  logic [3:0] active;
  logic frc_light;
  logic frc_dark;

  always_comb begin
    // Field holds count minus one; dark is stacked on light
    light_cnt = {1'b0, light_gray_count_field_in} + 4'h1;
    dark_sum = {1'b0, light_cnt} + {2'b00, dark_gray_delta_field_in} + 5'h01;
    // Clamp guards a host that breaks the fifteen-count limit
    dark_cnt = (dark_sum > {1'b0, PWM_BLACK}) ? PWM_BLACK : dark_sum[3:0];
  end

  always_comb begin
    case (pixel_in)
      2'b00: active = PWM_WHITE;
      2'b01: active = pwm_custom_select_in ? light_cnt : PWM_LIGHT_DEF;
      2'b10: active = pwm_custom_select_in ? dark_cnt : PWM_DARK_DEF;
      default: active = PWM_BLACK;
    endcase
  end

  always_comb begin
    if (!frc_length_select_in) begin
      frc_light = (frame_in == 2'h0);
      frc_dark = (frame_in < 2'h2);
    end else begin
      case (frc_pattern_select_in)
        2'b01: begin
          frc_light = (frame_in == 2'h0) || (frame_in == 2'h2);
          frc_dark = (frame_in < 2'h3);
        end
        2'b10: begin
          frc_light = (frame_in == 2'h0);
          frc_dark = (frame_in == 2'h0) || (frame_in == 2'h2);
        end
        default: begin
          frc_light = (frame_in == 2'h0);
          frc_dark = (frame_in < 2'h3);
        end
      endcase
    end
  end

  always_comb begin
    if (!gray_method_select_in) begin
      dark_out = (pwm_count_in < active);
    end else begin
      // Each frame is all 0 or all 15 counts
      case (pixel_in)
        2'b00: dark_out = 1'b0;
        2'b01: dark_out = frc_light;
        2'b10: dark_out = frc_dark;
        default: dark_out = 1'b1;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### lgs_ctrl.sv
// Purpose: Command decoder, gray shading timing and area scroll state
// Assumes: Host bytes arrive one per strobe, synchronous to mclk_in
// Notes: Analog, RAM addressing and line inversion live elsewhere
//
// How it works
// - Gray method 0 shades by PWM over 15 counts.
// - Custom select 1 uses host counts, 0 uses fixed defaults.
// - Custom mode keeps white at 0 and black at 15 counts.
// - Light field is count minus one; dark field is delta minus one.
// - Default PWM counts are 0, 5, 10 and 15.
// - Gray method 1 uses frame rate shading, 0 or 15 per frame.
// - Length select 0 gives three frames with the fixed pattern.
// - Length select 1 gives four frames; pattern field picks full frames.
// - Area scroll takes top, bottom, count and type in that order.
// - Scroll type 00 center, 01 top, 10 bottom, 11 whole screen.
// - Top blocks count up from 0, bottom blocks down from highest.
// - One scroll block spans four display lines.
// - Scroll start sets start block; only after an area scroll.
// - Duty command selects multiplex from 1/4 to 1/128 or 1/130.
// - Contrast command loads six-bit contrast, 64 steps.
// - Contrast command also loads a three-bit regulator gain.
// - A6 normal display, A7 inverse display.
// - A8 with parameters enters partial display, A9 leaves it.
// - AF display on, AE off; off with entire display on saves power.
// - 95 enters sleep, 94 leaves it.
// - D1 enables oscillator, D2 disables; disabled after reset.
`timescale 1ns/1ps
`default_nettype none
module lgs_ctrl
  import lgs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic byte_valid_in,
  input wire logic byte_is_data_in,
  input wire logic [7:0] byte_in,
  input wire logic entire_display_on_in,
  input wire logic [1:0] pixel_in,
  output logic busy_out,
  output logic seg_dark_out,
  output logic [7:0] line_out,
  output logic [5:0] line_block_out,
  output logic [3:0] pwm_count_out,
  output logic [1:0] frame_out,
  output logic [5:0] duty_code_out,
  output logic [5:0] contrast_out,
  output logic [2:0] regulator_resistor_select_out,
  output logic [5:0] scroll_top_out,
  output logic [5:0] scroll_bottom_out,
  output logic [5:0] scroll_count_out,
  output logic [1:0] scroll_type_select_out,
  output logic [5:0] scroll_start_out,
  output logic [7:0] partial_start_out,
  output logic [7:0] partial_end_out,
  output logic partial_mode_out,
  output logic inverse_out,
  output logic display_on_out,
  output logic power_save_out,
  output logic sleep_out,
  output logic osc_enable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder

  lgs_dec_type state;
  logic [7:0] opcode;
  logic [2:0] par_idx;
  logic [2:0] par_need;
  logic [2:0] par_need_cur;
  logic take_cmd;
  logic take_par;
  logic par_last;
  logic area_set;

  logic gray_method_select;
  logic pwm_custom_select;
  logic [2:0] light_gray_count_field;
  logic [2:0] dark_gray_delta_field;
  logic frc_length_select;
  logic [1:0] frc_pattern_select;

  always_comb begin
    case (byte_in)
      OP_GRAY: par_need = NPAR_GRAY;
      OP_DUTY: par_need = NPAR_DUTY;
      OP_AREA: par_need = NPAR_AREA;
      OP_START: par_need = NPAR_START;
      OP_CONTRAST: par_need = NPAR_CONTRAST;
      OP_PART_ON: par_need = NPAR_PART;
      default: par_need = 3'h0;
    endcase
  end

  // Opcodes that arrive while parameters are pending are dropped
  assign take_cmd = byte_valid_in && !byte_is_data_in && (state == LGS_IDLE);
  assign take_par = byte_valid_in && byte_is_data_in && (state == LGS_PARAM);
  assign par_last = (par_idx == (par_need_cur - 3'h1));

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= LGS_IDLE;
      opcode <= 8'h00;
      par_idx <= 3'h0;
      par_need_cur <= 3'h0;
    end else begin
      case (state)
        LGS_IDLE: begin
          if (take_cmd && (par_need != 3'h0)) begin
            state <= LGS_PARAM;
            opcode <= byte_in;
            par_idx <= 3'h0;
            par_need_cur <= par_need;
          end
        end
        LGS_PARAM: begin
          if (take_par) begin
            par_idx <= par_idx + 3'h1;
            if (par_last) begin
              state <= LGS_IDLE;
            end
          end
        end
        default: state <= LGS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state == LGS_IDLE) ? (take_cmd && (par_need != 3'h0))
                                      : !(take_par && par_last);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gray settings

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      gray_method_select <= 1'b0;
      pwm_custom_select <= 1'b0;
      light_gray_count_field <= 3'h0;
      dark_gray_delta_field <= 3'h0;
      frc_length_select <= 1'b0;
      frc_pattern_select <= 2'h0;
    end else if (take_par && opcode == OP_GRAY) begin
      if (par_idx == 3'h0) begin
        light_gray_count_field <= byte_in[2:0];
        dark_gray_delta_field <= byte_in[5:3];
      end else begin
        gray_method_select <= byte_in[0];
        frc_length_select <= byte_in[1];
        frc_pattern_select <= byte_in[3:2];
        pwm_custom_select <= byte_in[4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Area scroll, duty, contrast, partial area

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scroll_top_out <= BLOCK_TOP;
      scroll_bottom_out <= BLOCK_BOTTOM;
      scroll_count_out <= BLOCK_BOTTOM;
      scroll_type_select_out <= SCROLL_TYPE_RST;
      scroll_start_out <= BLOCK_TOP;
      area_set <= 1'b0;
    end else if (take_par && opcode == OP_AREA) begin
      case (par_idx)
        3'h0: begin
          scroll_top_out <= byte_in[5:0];
          // Start follows top until a scroll start arrives
          scroll_start_out <= byte_in[5:0];
        end
        3'h1: scroll_bottom_out <= byte_in[5:0];
        3'h2: scroll_count_out <= byte_in[5:0];
        default: begin
          scroll_type_select_out <= byte_in[1:0];
          area_set <= 1'b1;
        end
      endcase
    end else if (take_par && opcode == OP_START && area_set) begin
      scroll_start_out <= byte_in[5:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      duty_code_out <= DUTY_RST;
    end else if (take_par && opcode == OP_DUTY) begin
      // Codes above the top step all mean the 130-line duty
      duty_code_out <= (byte_in[5:0] > DUTY_CODE_MAX) ? DUTY_CODE_MAX
                                                     : byte_in[5:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      contrast_out <= CONTRAST_RST;
      regulator_resistor_select_out <= GAIN_RST;
    end else if (take_par && opcode == OP_CONTRAST) begin
      if (par_idx == 3'h0) begin
        contrast_out <= byte_in[5:0];
      end else begin
        regulator_resistor_select_out <= byte_in[2:0];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      partial_start_out <= 8'h00;
      partial_end_out <= 8'h00;
      partial_mode_out <= 1'b0;
    end else if (take_par && opcode == OP_PART_ON) begin
      if (par_idx == 3'h0) begin
        partial_start_out <= byte_in;
      end else begin
        partial_end_out <= byte_in;
        partial_mode_out <= 1'b1;
      end
    end else if (take_cmd && byte_in == OP_PART_OFF) begin
      partial_mode_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-byte mode commands

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      inverse_out <= 1'b0;
      display_on_out <= 1'b0;
      power_save_out <= 1'b0;
      sleep_out <= 1'b1;
      osc_enable_out <= 1'b0;
    end else if (take_cmd) begin
      case (byte_in)
        OP_NORMAL: inverse_out <= 1'b0;
        OP_INVERSE: inverse_out <= 1'b1;
        OP_DISP_ON: begin
          display_on_out <= 1'b1;
          power_save_out <= 1'b0;
        end
        OP_DISP_OFF: begin
          display_on_out <= 1'b0;
          power_save_out <= entire_display_on_in;
        end
        OP_SLEEP_IN: sleep_out <= 1'b1;
        OP_SLEEP_OUT: sleep_out <= 1'b0;
        OP_OSC_ON: osc_enable_out <= 1'b1;
        OP_OSC_OFF: osc_enable_out <= 1'b0;
        default: begin
          // NOP and unknown opcodes change nothing
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shading timing: PWM count, line, frame

  logic running;
  logic [7:0] mux_lines;
  logic [1:0] frame_last;
  logic line_wrap;
  logic pwm_wrap;

  // Timing stops with no oscillator or in sleep, as the panel would
  assign running = osc_enable_out && !sleep_out;
  assign pwm_wrap = (pwm_count_out == PWM_LAST);
  assign line_wrap = pwm_wrap && ((line_out + 8'h01) >= mux_lines);
  assign frame_last = frc_length_select ? FRC4_LAST : FRC3_LAST;

  always_comb begin
    if (duty_code_out == DUTY_CODE_MAX) begin
      mux_lines = MUX_MAX_LINES;
    end else begin
      mux_lines = {duty_code_out[5:0] + 6'h01, 2'b00};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pwm_count_out <= 4'h0;
    end else if (running) begin
      pwm_count_out <= pwm_wrap ? 4'h0 : pwm_count_out + 4'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      line_out <= 8'h00;
      line_block_out <= 6'h00;
    end else if (running && pwm_wrap) begin
      line_out <= line_wrap ? 8'h00 : line_out + 8'h01;
      line_block_out <= line_wrap ? 6'h00
                                  : 6'((line_out + 8'h01) >> LINES_PER_BLOCK_LOG2);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      frame_out <= 2'h0;
    end else if (running && line_wrap) begin
      frame_out <= (frame_out >= frame_last) ? 2'h0 : frame_out + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel drive

  logic [1:0] shade_pixel;
  logic shade_dark;
  logic in_partial;

  // Inverse swaps white with black and light with dark
  assign shade_pixel = inverse_out ? ~pixel_in : pixel_in;
  assign in_partial = !partial_mode_out ||
                      ((line_out >= partial_start_out) && (line_out <= partial_end_out));

  lgs_shade u_shade (
    .pixel_in(shade_pixel),
    .gray_method_select_in(gray_method_select),
    .pwm_custom_select_in(pwm_custom_select),
    .light_gray_count_field_in(light_gray_count_field),
    .dark_gray_delta_field_in(dark_gray_delta_field),
    .frc_length_select_in(frc_length_select),
    .frc_pattern_select_in(frc_pattern_select),
    .pwm_count_in(pwm_count_out),
    .frame_in(frame_out),
    .dark_out(shade_dark)
  );

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      seg_dark_out <= 1'b0;
    end else begin
      seg_dark_out <= shade_dark && display_on_out && running && in_partial;
    end
  end

endmodule
`default_nettype wire

// ### lgs_host.sv
// Purpose: Host model that feeds command and parameter bytes to the controller
// Assumes: Bytes change on the falling edge and are taken on the next rising edge
// Notes: Released byte lines show the inverse of the last byte, never stale data
`timescale 1ns/1ps
`default_nettype none
module lgs_host (
  input wire logic mclk_in,
  output logic byte_valid_out,
  output logic byte_is_data_out,
  output logic [7:0] byte_out
);
  initial begin
    byte_valid_out = 1'b0;
    byte_is_data_out = 1'b0;
    byte_out = 8'h00;
  end
  // One byte per cycle, parameters follow their opcode in order
  task automatic send(input logic dc, input logic [7:0] b);
    @(negedge mclk_in);
    byte_valid_out = 1'b1;
    byte_is_data_out = dc;
    byte_out = b;
  endtask
  task automatic release_bus();
    @(negedge mclk_in);
    byte_valid_out = 1'b0;
    byte_is_data_out = ~byte_is_data_out;
    byte_out = ~byte_out;
  endtask
endmodule
`default_nettype wire

// ### lgs_ctrl_asserts.sv
// Purpose: Concurrent checks on the command decoder and shading timing
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to every lgs_ctrl instance below the module
`timescale 1ns/1ps
`default_nettype none
module lgs_ctrl_asserts
  import lgs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic byte_valid_in,
  input wire logic byte_is_data_in,
  input wire logic [7:0] byte_in,
  input wire logic entire_display_on_in,
  input wire logic busy_out,
  input wire logic seg_dark_out,
  input wire logic [7:0] line_out,
  input wire logic [5:0] line_block_out,
  input wire logic [3:0] pwm_count_out,
  input wire logic [5:0] contrast_out,
  input wire logic inverse_out,
  input wire logic partial_mode_out,
  input wire logic display_on_out,
  input wire logic power_save_out,
  input wire logic sleep_out,
  input wire logic osc_enable_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic op_take;
  logic run;
  assign op_take = byte_valid_in && !byte_is_data_in && !busy_out;
  assign run = osc_enable_out && !sleep_out;
  ////////////////////////////////////////
  // Bit 0 of each paired opcode gives the new flag value
  a_osc_cmds: assert property ((op_take && (byte_in == OP_OSC_ON ||
    byte_in == OP_OSC_OFF)) |=> osc_enable_out == $past(byte_in[0]))
    else $error("oscillator flag wrong");
  a_sleep_cmds: assert property ((op_take && byte_in[7:1] == OP_SLEEP_OUT[7:1])
    |=> sleep_out == $past(byte_in[0])) else $error("sleep flag wrong");
  a_inverse_cmds: assert property ((op_take && byte_in[7:1] == OP_NORMAL[7:1])
    |=> inverse_out == $past(byte_in[0])) else $error("inverse flag wrong");
  a_display_onoff: assert property ((op_take && byte_in[7:1] == OP_DISP_OFF[7:1])
    |=> display_on_out == $past(byte_in[0])
    && power_save_out == (!$past(byte_in[0]) && $past(entire_display_on_in)))
    else $error("display or power save flag wrong");
  a_partial_exit: assert property ((op_take && byte_in == OP_PART_OFF)
    |=> !partial_mode_out) else $error("partial mode not left");
  a_contrast_load: assert property ((op_take && byte_in == OP_CONTRAST)
    ##1 (byte_valid_in && byte_is_data_in) |=> contrast_out == $past(byte_in[5:0]))
    else $error("contrast not loaded");
  a_area_busy: assert property ((op_take && byte_in == OP_AREA) |=> busy_out[*4])
    else $error("area scroll released early");
  a_pwm_step: assert property (run |=> pwm_count_out ==
    (($past(pwm_count_out) == PWM_LAST) ? 4'h0 : $past(pwm_count_out) + 4'h1))
    else $error("pwm count step wrong");
  a_pwm_hold: assert property (!osc_enable_out |=> $stable(pwm_count_out))
    else $error("pwm counting with oscillator off");
  a_dark_gate: assert property (!display_on_out |=> !seg_dark_out)
    else $error("pixel driven with display off");
  a_block_line: assert property (line_block_out == line_out[7:2])
    else $error("block index not line over four");
  c_area: cover property (op_take && byte_in == OP_AREA);
  c_dark: cover property ($rose(seg_dark_out));
  c_save: cover property ($rose(power_save_out));
endmodule
bind lgs_ctrl lgs_ctrl_asserts chk_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .byte_valid_in(byte_valid_in), .byte_is_data_in(byte_is_data_in), .byte_in(byte_in),
  .entire_display_on_in(entire_display_on_in), .busy_out(busy_out),
  .seg_dark_out(seg_dark_out), .line_out(line_out), .line_block_out(line_block_out),
  .pwm_count_out(pwm_count_out), .contrast_out(contrast_out), .inverse_out(inverse_out),
  .partial_mode_out(partial_mode_out), .display_on_out(display_on_out),
  .power_save_out(power_save_out), .sleep_out(sleep_out), .osc_enable_out(osc_enable_out));
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the grayscale and scroll controller
// Assumes: Host model drives bytes; pixel and entire-on driven here
// Notes: Shade counted over one whole PWM or frame cycle, so no alignment needed
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lgs_pkg::*;
  logic mclk_in, sys_rst_in, ent, bv, bd, busy, dark, pmode, inv, don, psave, slp, osc;
  logic [1:0] pix, frame, stype;
  logic [2:0] gain;
  logic [3:0] pwm;
  logic [5:0] block, duty, contrast, stop, sbot, scnt, sstart;
  logic [7:0] bb, line, pstart, pend;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  lgs_host host_u (.mclk_in(mclk_in), .byte_valid_out(bv), .byte_is_data_out(bd),
    .byte_out(bb));
  lgs_ctrl dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .byte_valid_in(bv),
    .byte_is_data_in(bd), .byte_in(bb), .entire_display_on_in(ent), .pixel_in(pix),
    .busy_out(busy), .seg_dark_out(dark), .line_out(line), .line_block_out(block),
    .pwm_count_out(pwm), .frame_out(frame), .duty_code_out(duty), .contrast_out(contrast),
    .regulator_resistor_select_out(gain), .scroll_top_out(stop), .scroll_bottom_out(sbot),
    .scroll_count_out(scnt), .scroll_type_select_out(stype), .scroll_start_out(sstart),
    .partial_start_out(pstart), .partial_end_out(pend), .partial_mode_out(pmode),
    .inverse_out(inv), .display_on_out(don), .power_save_out(psave), .sleep_out(slp),
    .osc_enable_out(osc));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] p, input int n);
    host_u.send(1'b0, c);
    for (int i = 0; i < n; i++) host_u.send(1'b1, p[8*i +: 8]);
    host_u.release_bus();
    @(negedge mclk_in);
  endtask
  // Dark cycles per pixel value over one full cycle of w clocks
  task automatic shade(input logic [15:0] p, input int w, input int u, input logic [15:0] k);
    int n;
    cmd(OP_GRAY, {16'h0000, p}, 2);
    for (int px = 0; px < 4; px++) begin
      pix = px[1:0];
      repeat (4) @(negedge mclk_in);
      n = 0;
      repeat (w) begin
        @(negedge mclk_in);
        if (dark === 1'b1) n++;
      end
      chk(n, k[4*px +: 4] * u);
    end
  endtask
  initial begin
    forever begin
      @(posedge mclk_in);
      cyc++;
      if (cyc == 40000) begin
        num_errors++;
        close_out();
      end
    end
  end
  ////////////////////////////////////////
  initial begin
    sys_rst_in = 1'b1;
    ent = 1'b0;
    pix = 2'h0;
    repeat (4) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    chk({duty, contrast, gain}, {6'h1f, 6'h20, 3'h0});
    chk({stop, sbot, scnt, stype, sstart}, {6'h00, 6'h20, 6'h20, 2'h0, 6'h00});
    chk({slp, osc, don, inv, pmode, psave, busy}, 7'b1000000);
    cmd(OP_CONTRAST, 32'h0514, 2);
    chk({contrast, gain}, {6'h14, 3'h5});
    // An opcode inside a parameter run must be dropped
    host_u.send(1'b0, OP_CONTRAST);
    host_u.send(1'b0, OP_INVERSE);
    host_u.send(1'b1, 8'h3f);
    host_u.send(1'b1, 8'h07);
    host_u.release_bus();
    @(negedge mclk_in);
    chk({contrast, gain, inv}, {6'h3f, 3'h7, 1'b0});
    cmd(OP_DUTY, 32'h10, 1);
    chk(duty, 6'h10);
    cmd(OP_DUTY, 32'h3f, 1);
    chk(duty, DUTY_CODE_MAX);
    cmd(OP_START, 32'h05, 1);
    chk(sstart, 6'h00);
    for (int t = 0; t < 4; t++) begin
      cmd(OP_AREA, {6'h00, t[1:0], 24'h191d02}, 4);
      chk({stop, sbot, scnt, stype, sstart}, {6'h02, 6'h1d, 6'h19, t[1:0], 6'h02});
    end
    cmd(OP_START, 32'h07, 1);
    chk(sstart, 6'h07);
    cmd(OP_INVERSE, 32'h0, 0);
    chk(inv, 1'b1);
    cmd(OP_NORMAL, 32'h0, 0);
    chk(inv, 1'b0);
    cmd(OP_PART_ON, 32'h2010, 2);
    chk({pmode, pstart, pend}, {1'b1, 8'h10, 8'h20});
    cmd(OP_PART_OFF, 32'h0, 0);
    chk(pmode, 1'b0);
    cmd(OP_NOP, 32'h0, 0);
    chk({duty, contrast, sstart, inv}, {6'h20, 6'h3f, 6'h07, 1'b0});
    cmd(OP_OSC_ON, 32'h0, 0);
    chk(osc, 1'b1);
    cmd(OP_SLEEP_OUT, 32'h0, 0);
    chk(slp, 1'b0);
    cmd(OP_SLEEP_IN, 32'h0, 0);
    chk(slp, 1'b1);
    cmd(OP_SLEEP_OUT, 32'h0, 0);
    cmd(OP_DISP_ON, 32'h0, 0);
    chk({don, psave}, 2'b10);
    cmd(OP_DUTY, 32'h03, 1);
    shade(16'h0000, 15, 1, 16'hfa50);
    ent = 1'b1;
    cmd(OP_DISP_OFF, 32'h0, 0);
    chk({don, psave}, 2'b01);
    shade(16'h0000, 15, 1, 16'h0000);
    cmd(OP_DISP_ON, 32'h0, 0);
    chk({don, psave}, 2'b10);
    ent = 1'b0;
    shade(16'h103a, 15, 1, 16'hfb30);
    cmd(OP_INVERSE, 32'h0, 0);
    shade(16'h0000, 15, 1, 16'h05af);
    cmd(OP_NORMAL, 32'h0, 0);
    // Lines 0 to 7 of 16 shown: half of every shade
    cmd(OP_PART_ON, 32'h0700, 2);
    shade(16'h0000, 240, 8, 16'hfa50);
    cmd(OP_PART_OFF, 32'h0, 0);
    shade(16'h0100, 720, 240, 16'h3210);
    shade(16'h0300, 960, 240, 16'h4310);
    shade(16'h0700, 960, 240, 16'h4320);
    shade(16'h0b00, 960, 240, 16'h4210);
    cmd(OP_OSC_OFF, 32'h0, 0);
    chk({osc, dark}, 2'b00);
    close_out();
  end
endmodule
`default_nettype wire
